// >>> common/sfc_pkg.sv
// package: register map, field layout, reset values and state types of the spi fault/irq control block
`default_nettype none
package sfc_pkg;

   // ************************************************************
   // register indexes and byte addresses
   // ************************************************************
   // printed offsets are not all word aligned, so they are indexes and the byte address is four times the index
   localparam logic [9:0]  STATUS_IDX  = 10'h0C4;
   localparam logic [9:0]  DATA_IDX    = 10'h0C5;
   localparam logic [9:0]  CTRL_IDX    = 10'h0D4;
   localparam logic [11:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
   localparam logic [11:0] DATA_ADDR   = {DATA_IDX, 2'b00};
   localparam logic [11:0] CTRL_ADDR   = {CTRL_IDX, 2'b00};

   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int RATE_HI_BIT  = 7;
   localparam int EN_BIT       = 6;
   localparam int SELECT_DISABLE_BIT    = 5;
   localparam int MASTER_SELECT_BIT     = 4;
   localparam int CPOL_BIT     = 3;
   localparam int CPHA_BIT     = 2;
   localparam int RATE_MID_BIT = 1;
   localparam int RATE_LO_BIT  = 0;
   localparam logic [7:0] CTRL_RESET = 8'h14;

   // ************************************************************
   // status register fields
   // ************************************************************
   localparam int DONE_BIT    = 7;
   localparam int OVR_BIT     = 5;
   localparam int FAULT_BIT   = 4;
   localparam int TXE_BIT     = 3;
   localparam int LSBF_BIT    = 2;
   localparam int TXEIE_BIT   = 1;
   localparam int FAULTIE_BIT = 0;

   // ************************************************************
   // timing
   // ************************************************************
   localparam logic [6:0] HALF_BASE = 7'h02;   // half period of sck at the /4 rate, in clk cycles
   localparam logic [3:0] LAST_EDGE = 4'hF;    // sixteen sck edges make one byte
   localparam logic [1:0] AHB_NONSEQ = 2'b10;
   localparam logic [2:0] AHB_WORD   = 3'b010;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_RUN = 1'b1} sfc_phase_e;

   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic ssN;
   } sfc_pins_in_s;

   typedef struct packed {
      logic sckOut;
      logic sckOe;
      logic mosiOut;
      logic mosiOe;
      logic misoOut;
      logic misoOe;
   } sfc_pins_out_s;

   typedef struct packed {
      logic [7:0]    ctrl;
      logic          txeIe;
      logic          faultIe;
      logic          lsbFirst;
      logic          doneFlag;
      logic          ovrFlag;
      logic          faultFlag;
      logic          txEmpty;
      logic          doneArm;
      logic          faultArm;
      logic [7:0]    rxData;
      logic [7:0]    shift;
      logic [7:0]    txBuf;
      logic          txFull;
      logic          inBit;
      logic [3:0]    edgeCnt;
      sfc_phase_e    phase;
      logic          slvActive;
      logic [6:0]    divCnt;
      logic [2:0]    ssS;
      logic [2:0]    sckS;
      logic [2:0]    mosiS;
      logic [2:0]    misoS;
      logic          ssLvl;
      logic          sckLvl;
      logic          mosiLvl;
      logic          misoLvl;
      sfc_pins_out_s pins;
      logic          irq;
      logic          dph;
      logic          dWrite;
      logic [11:0]   dAddr;
      logic          hreadyout;
      logic          hresp;
      logic [31:0]   hrdata;
   } sfc_state_s;

   localparam sfc_state_s STATE_RESET = '{ctrl: CTRL_RESET, txEmpty: 1'b1, phase: ST_IDLE, ssS: 3'b111,
                                          ssLvl: 1'b1, hreadyout: 1'b1, default: '0};

endpackage
`default_nettype wire

// >>> logic/sfc_spi_ctrl.sv
// module: spi port with mode-fault and overrun detection, interrupt request and control register, ahb-lite slave
//
// Functional notes
// - master with select in use: select pin low sets the mode-fault flag.
// - master mode fault raises interrupt and clears enable and master-select bits.
// - mode fault clears by status read with flag set, then control write.
// - select disabled: no mode fault; master unselected, slave selected internally, except a slave with phase clear.
// - slave: select rising after low during a transfer sets mode fault.
// - slave transfer starts on select fall, ends when sck returns idle after bit eight.
// - select high: miso released, edge counter cleared, sck edges ignored.
// - byte completing while previous unread sets overrun, keeps old byte.
// - transfer done flag set at byte end; interrupts only with tx-empty enable clear.
// - tx-empty flag set when buffer free; interrupts only with its enable set.
// - mode fault is a third interrupt source, in master and slave modes.
// - control layout: rate high, enable, select-disable, master, polarity, phase, rate low two.
// - enable clear disables port and resets its internal state.
// - select-disable ignores select except in slave phase zero; blocks fault interrupts in every mode.
// - master-select clear makes a slave, set makes the sck-driving master.
// - polarity bit sets idle level of sck: clear low, set high.
// - phase clear samples on edge leaving idle, set on edge returning idle.
// - rate codes 001..110 divide by 4..128; 000 and 111 invalid.
// - status read clears the overrun flag.
// - data read or write after status read clears transfer done flag.
// - mode-fault interrupt enable in status register gates fault requests.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module sfc_spi_ctrl
   import sfc_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output var  logic          hreadyout,
   output var  logic          hresp,
   output var  logic [31:0]   hrdata,
   input  wire sfc_pins_in_s  pinsIn,
   output var  sfc_pins_out_s pinsOut,
   output var  logic          irq
);

   // ************************************************************
   // helpers
   // ************************************************************
   // a pin level is accepted only once the second and third stages agree
   function automatic logic settle(input logic [2:0] s, input logic lvl);
      settle = (s[1] == s[2]) ? s[2] : lvl;
   endfunction

   // lsb-first mode mirrors the byte on its way in and out of the shifter
   function automatic logic [7:0] order(input logic [7:0] b, input logic lsbFirst);
      logic [7:0] m;
      m = '0;
      for (int i = 0; i < 8; i++) begin
         m[i] = b[7 - i];
      end
      order = lsbFirst ? m : b;
   endfunction

   // half period of the master sck for the three rate bits; zero marks an invalid code
   function automatic logic [6:0] halfPeriod(input logic [2:0] code);
      if (code == 3'b000 || code == 3'b111) begin
         halfPeriod = '0;
      end else begin
         halfPeriod = 7'(HALF_BASE << (code - 3'b001));
      end
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   sfc_state_s r;
   sfc_state_s n;

   logic       en;
   logic       master;
   logic       cpol;
   logic       cpha;
   logic       ssdisEff;
   logic       selected;
   logic       ssNow;
   logic       sckNow;
   logic       din;
   logic       edgeFire;
   logic       leading;
   logic       byteDone;
   logic [7:0] rxByte;
   logic [6:0] half;
   logic       accept;
   logic       statRd;
   logic       dataRd;
   logic       dataWr;
   logic       ctrlWr;
   logic       statWr;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      n = r;
      en = r.ctrl[EN_BIT];
      master = r.ctrl[MASTER_SELECT_BIT];
      cpol = r.ctrl[CPOL_BIT];
      cpha = r.ctrl[CPHA_BIT];
      half = halfPeriod({r.ctrl[RATE_HI_BIT], r.ctrl[RATE_MID_BIT], r.ctrl[RATE_LO_BIT]});
      edgeFire = 1'b0;
      leading = 1'b0;
      byteDone = 1'b0;
      rxByte = '0;

      // three-stage synchronisers; only the settled levels are used below
      n.ssS = {r.ssS[1:0], pinsIn.ssN};
      n.sckS = {r.sckS[1:0], pinsIn.sck};
      n.mosiS = {r.mosiS[1:0], pinsIn.mosi};
      n.misoS = {r.misoS[1:0], pinsIn.miso};
      ssNow = settle(r.ssS, r.ssLvl);
      sckNow = settle(r.sckS, r.sckLvl);
      n.ssLvl = ssNow;
      n.sckLvl = sckNow;
      n.mosiLvl = settle(r.mosiS, r.mosiLvl);
      n.misoLvl = settle(r.misoS, r.misoLvl);

      // select-disable only counts for a slave when phase is one
      ssdisEff = r.ctrl[SELECT_DISABLE_BIT] & (master | cpha);
      selected = ssdisEff | ~ssNow;
      din = master ? r.misoLvl : r.mosiLvl;

      // bus decode: strobes act in the data phase, one wait state after the address phase
      accept = hsel & hready & (htrans == AHB_NONSEQ) & (hsize == AHB_WORD);
      statRd = r.dph & ~r.dWrite & (r.dAddr == STATUS_ADDR);
      dataRd = r.dph & ~r.dWrite & (r.dAddr == DATA_ADDR);
      dataWr = r.dph & r.dWrite & (r.dAddr == DATA_ADDR);
      ctrlWr = r.dph & r.dWrite & (r.dAddr == CTRL_ADDR);
      statWr = r.dph & r.dWrite & (r.dAddr == STATUS_ADDR);

      // bus data phase: read data, register writes and flag clears come first so that sets below win
      n.hreadyout = 1'b1;
      n.dph = 1'b0;
      if (r.dph && !r.dWrite) begin
         n.hrdata = '0;
         unique case (r.dAddr)
            STATUS_ADDR: n.hrdata[7:0] = {r.doneFlag, 1'b0, r.ovrFlag, r.faultFlag, r.txEmpty,
                                          r.lsbFirst, r.txeIe, r.faultIe};
            DATA_ADDR:   n.hrdata[7:0] = r.rxData;
            CTRL_ADDR:   n.hrdata[7:0] = r.ctrl;
            default:     n.hrdata = '0;                                 // unmapped reads as zero
         endcase
      end
      if (statRd) begin
         n.ovrFlag = 1'b0;
         n.doneArm = r.doneFlag;
         n.faultArm = r.faultFlag;
      end
      if ((dataRd || dataWr) && r.doneArm) begin
         n.doneFlag = 1'b0;
         n.doneArm = 1'b0;
      end
      if (statWr) begin
         n.lsbFirst = hwdata[LSBF_BIT];
         n.txeIe = hwdata[TXEIE_BIT];
         n.faultIe = hwdata[FAULTIE_BIT];
      end
      if (ctrlWr) begin
         n.ctrl = hwdata[7:0];
         if (r.faultArm) begin
            n.faultFlag = 1'b0;
            n.faultArm = 1'b0;
         end
      end
      if (accept) begin
         n.dph = 1'b1;
         n.dWrite = hwrite;
         n.dAddr = haddr[11:0];
         n.hreadyout = 1'b0;
      end

      // shift engine: a disabled port holds its shifter idle and forgets a byte in progress
      if (!en) begin
         n.phase = ST_IDLE;
         n.edgeCnt = '0;
         n.divCnt = '0;
         n.slvActive = 1'b0;
         n.pins.sckOut = cpol;
      end else if (master) begin
         // the master makes sck from the divider and starts as soon as a byte waits and the rate code is valid
         if (r.phase == ST_IDLE) begin
            n.pins.sckOut = cpol;
            if (r.txFull && half != '0) begin
               n.shift = order(r.txBuf, r.lsbFirst);
               n.txFull = 1'b0;
               n.phase = ST_RUN;
               n.divCnt = '0;
               n.edgeCnt = '0;
            end
         end else if (r.divCnt >= half - 7'h01) begin
            n.divCnt = '0;
            n.pins.sckOut = ~r.pins.sckOut;
            edgeFire = 1'b1;
         end else begin
            n.divCnt = r.divCnt + 7'h01;
         end
      end else begin
         // slave: deselection ends the byte at once and drops every sck edge
         if (!selected) begin
            n.edgeCnt = '0;
            n.phase = ST_IDLE;
         end else begin
            if (r.phase == ST_IDLE && r.txFull) begin
               n.shift = order(r.txBuf, r.lsbFirst);
               n.txFull = 1'b0;
            end
            if (sckNow != r.sckLvl) begin
               edgeFire = 1'b1;
               n.phase = ST_RUN;
               n.slvActive = 1'b1;
            end
         end
         if (r.ssLvl && !ssNow) begin
            n.slvActive = 1'b1;
         end
      end

      // one sck edge: the sampling edge catches a bit, the other one moves the shifter
      if (edgeFire) begin
         leading = ~r.edgeCnt[0];
         if (leading ^ cpha) begin
            n.inBit = din;
         end else if (r.edgeCnt != '0) begin
            n.shift = {r.shift[6:0], r.inBit};
         end
         if (r.edgeCnt == LAST_EDGE) begin
            // the sixteenth edge always returns sck to idle, so the byte ends here
            byteDone = 1'b1;
            rxByte = {r.shift[6:0], cpha ? din : r.inBit};
            n.shift = rxByte;
            n.phase = ST_IDLE;
            n.edgeCnt = '0;
            n.slvActive = 1'b0;
         end else begin
            n.edgeCnt = r.edgeCnt + 4'h1;
         end
      end

      // a finished byte is kept only if the last one was collected
      if (byteDone) begin
         if (n.doneFlag) begin
            n.ovrFlag = 1'b1;
         end else begin
            n.rxData = order(rxByte, r.lsbFirst);
            n.doneFlag = 1'b1;
         end
      end

      // slave mode fault: select lifted mid-transfer, even with no sck seen
      if (en && !master && !ssdisEff && r.slvActive && !r.ssLvl && ssNow) begin
         n.faultFlag = 1'b1;
         n.slvActive = 1'b0;
      end

      // master mode fault: another master pulls select low; the port shuts itself down
      if (en && master && !r.ctrl[SELECT_DISABLE_BIT] && !ssNow) begin
         n.faultFlag = 1'b1;
         n.ctrl[EN_BIT] = 1'b0;
         n.ctrl[MASTER_SELECT_BIT] = 1'b0;
         n.phase = ST_IDLE;
         n.edgeCnt = '0;
      end

      // a data write lands last so a load in the same cycle cannot swallow it; a full buffer is overwritten
      if (dataWr) begin
         n.txBuf = hwdata[7:0];
         n.txFull = 1'b1;
      end
      n.txEmpty = ~n.txFull;

      // pin drivers follow the shifter; miso floats whenever the slave is not selected
      n.pins.mosiOut = n.shift[7];
      n.pins.misoOut = n.shift[7];
      n.pins.sckOe = n.ctrl[EN_BIT] & n.ctrl[MASTER_SELECT_BIT];
      n.pins.mosiOe = n.ctrl[EN_BIT] & n.ctrl[MASTER_SELECT_BIT];
      n.pins.misoOe = n.ctrl[EN_BIT] & ~n.ctrl[MASTER_SELECT_BIT]
                      & ((n.ctrl[SELECT_DISABLE_BIT] & n.ctrl[CPHA_BIT]) | ~ssNow);

      // one level request from all enabled sources; tx-empty enable picks between the two data sources
      n.irq = (n.txeIe ? n.txEmpty : n.doneFlag)
              | (n.faultFlag & n.faultIe & ~n.ctrl[SELECT_DISABLE_BIT]);
   end

   // ************************************************************
   // registers
   // ************************************************************
   // the whole block state sits in one register; reset loads constants only
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= STATE_RESET;
      end else begin
         r <= n;
      end
   end

   // every output is a field of the state register
   assign hreadyout = r.hreadyout;
   assign hresp = r.hresp;
   assign hrdata = r.hrdata;
   assign pinsOut = r.pins;
   assign irq = r.irq;

endmodule
`default_nettype wire

// >>> verif/sfc_spi_ctrl_assertions.sv
// checker: bus wait state, pin enables, select handling and sck pacing of the spi control block
`timescale 1ns/100ps
`default_nettype none
module sfc_spi_ctrl_assertions
   import sfc_pkg::*;
(
   input wire logic          clk,
   input wire logic          reset,
   input wire logic          hsel,
   input wire logic [31:0]   haddr,
   input wire logic [1:0]    htrans,
   input wire logic          hwrite,
   input wire logic [2:0]    hsize,
   input wire logic [31:0]   hwdata,
   input wire logic          hready,
   input wire logic          hreadyout,
   input wire sfc_pins_in_s  pinsIn,
   input wire sfc_pins_out_s pinsOut
);
   // ****************
   // control shadow
   // ****************
   logic       take;
   logic       wrPend_r;
   logic       ctrlWr_r;
   logic [7:0] ctrlT_r;
   assign take = hsel && hready && htrans == AHB_NONSEQ && hsize == AHB_WORD;
   // only select-disable and phase are trusted later: a fault may clear enable and master behind our back
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wrPend_r <= 1'b0;
         ctrlWr_r <= 1'b0;
         ctrlT_r  <= CTRL_RESET;
      end else begin
         ctrlWr_r <= wrPend_r && !hreadyout;
         if (wrPend_r && !hreadyout) begin
            ctrlT_r  <= hwdata[7:0];
            wrPend_r <= 1'b0;
         end
         if (take) begin
            wrPend_r <= hwrite && haddr[11:0] == CTRL_ADDR;
         end
      end
   end
   // ****************
   // properties
   // ****************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_unselected;
      pinsIn.ssN [*8] ##0 !(ctrlT_r[SELECT_DISABLE_BIT] && ctrlT_r[CPHA_BIT]);
   endsequence
   a_one_wait: assert property (take |=> s_wait)
      else $error("bus transfer without its single wait state");
   a_miso_release: assert property (s_unselected |-> !pinsOut.misoOe)
      else $error("miso driven while unselected");
   a_sck_half: assert property (pinsOut.sckOe && $changed(pinsOut.sckOut) |=> $stable(pinsOut.sckOut))
      else $error("sck half period below two clocks");
   a_fault_stop: assert property ($fell(pinsIn.ssN) && pinsOut.sckOe && !ctrlT_r[SELECT_DISABLE_BIT]
      |-> ##[1:8] !pinsOut.sckOe) else $error("master kept driving after select fault");
   a_select_disable_keep: assert property (pinsOut.sckOe && ctrlT_r[SELECT_DISABLE_BIT] && hreadyout && !ctrlWr_r
      |=> pinsOut.sckOe) else $error("master dropped with select disabled");
   a_disable_quiet: assert property (ctrlWr_r && !ctrlT_r[EN_BIT] |=> !pinsOut.sckOe && !pinsOut.misoOe)
      else $error("pins still driven after disable");
   a_master_drive: assert property (ctrlWr_r && ctrlT_r[EN_BIT] && ctrlT_r[MASTER_SELECT_BIT] && pinsIn.ssN
      |=> pinsOut.sckOe) else $error("enabled master not driving sck");
   a_slave_quiet: assert property (ctrlWr_r && !ctrlT_r[MASTER_SELECT_BIT] |=> !pinsOut.sckOe && !pinsOut.mosiOe)
      else $error("slave driving sck or mosi");
endmodule
`default_nettype wire

// >>> verif/sfc_far_end.sv
// far-end model: spi slave answering our master, spi master driving our slave
`timescale 1ns/100ps
`default_nettype none
module sfc_far_end
   import sfc_pkg::*;
(
   input  wire logic          clk,
   input  wire sfc_pins_out_s pinsOut,
   output var  sfc_pins_in_s  pinsIn
);
   localparam int HALF = 8;
   logic [7:0] slvTx_r = 8'h00;
   logic [7:0] slvRx_r = 8'h00;
   logic [7:0] mRx_r   = 8'h00;
   logic       prevSck_r = 1'b0;
   logic       tog_r     = 1'b0;
   logic       ssN_r     = 1'b1;
   logic       sck_r     = 1'b0;
   logic       mosi_r    = 1'b0;
   logic       inFrame_r = 1'b0;
   int         halfCnt   = 0;
   int         lastHalf  = 0;
   int         edges     = 0;
   // undriven lines toggle so a stale value never looks valid
   assign pinsIn = '{sck: sck_r, mosi: inFrame_r ? mosi_r : tog_r, miso: pinsOut.sckOe ? slvTx_r[7] : tog_r,
                     ssN: ssN_r};
   // slave side: sample on leaving idle, shift on return, measure half period
   always @(posedge clk) begin
      tog_r     <= ~tog_r;
      prevSck_r <= pinsOut.sckOut;
      halfCnt   <= halfCnt + 1;
      if (pinsOut.sckOe && pinsOut.sckOut != prevSck_r) begin
         edges    <= edges + 1;
         lastHalf <= halfCnt;
         halfCnt  <= 1;
         if (pinsOut.sckOut) begin
            slvRx_r <= {slvRx_r[6:0], pinsOut.mosiOut};
         end else begin
            slvTx_r <= {slvTx_r[6:0], slvTx_r[0]};
         end
      end
   end
   task automatic load(input logic [7:0] b);
      slvTx_r = b;
   endtask
   task automatic selectLevel(input logic v);
      @(posedge clk);
      ssN_r <= v;
   endtask
   // master side: select held low over the whole frame, mode 0 timing
   task automatic send(input logic [7:0] b, input int nEdges);
      logic [7:0] sh;
      int         i;
      sh = b;
      @(posedge clk);
      ssN_r     <= 1'b0;
      inFrame_r <= 1'b1;
      mosi_r    <= sh[7];
      repeat (HALF) @(posedge clk);
      for (i = 0; i < nEdges; i++) begin
         if (!sck_r) begin
            mRx_r <= {mRx_r[6:0], pinsOut.misoOe ? pinsOut.misoOut : ~pinsOut.misoOut};
         end else begin
            sh = sh << 1;
            mosi_r <= sh[7];
         end
         sck_r <= ~sck_r;
         repeat (HALF) @(posedge clk);
      end
      ssN_r     <= 1'b1;
      inFrame_r <= 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> verif/sfc_spi_ctrl_tb.sv
// testbench: register bus, master and slave transfers, faults and interrupt of the spi control block
`timescale 1ns/100ps
`default_nettype none
module sfc_spi_ctrl_tb
   import sfc_pkg::*;
   ;
   logic          clk = 1'b0;
   logic          reset;
   logic          hsel;
   logic [31:0]   haddr;
   logic [1:0]    htrans;
   logic          hwrite;
   logic [2:0]    hsize;
   logic [31:0]   hwdata;
   wire logic     hready;
   logic          hreadyout;
   logic          hresp;
   logic [31:0]   hrdata;
   sfc_pins_in_s  pinsIn;
   sfc_pins_out_s pinsOut;
   logic          irq;
   int            err_count = 0;
   int            comparisons = 0;
   assign hready = hreadyout;
   always #2.5 clk = ~clk;
   sfc_spi_ctrl uut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pinsIn(pinsIn), .pinsOut(pinsOut), .irq(irq));
   sfc_far_end far (.clk(clk), .pinsOut(pinsOut), .pinsIn(pinsIn));
   // ****************
   // shared tasks
   // ****************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one single word transfer; waits are bounded rather than assuming the wait state
   task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd, output logic [31:0] rd);
      int n;
      n = 0;
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, a};
      hwrite <= wr;
      htrans <= AHB_NONSEQ;
      @(posedge clk);
      while (hready !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= {24'h00_0000, wd};
      @(posedge clk);
      while (hready !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      rd = hrdata;
      if (n >= 100) err_count++;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] rd;
      bus(1'b0, a, 8'h00, rd);
      check(rd, {24'h00_0000, e});
      check(hresp, 1'b0);
   endtask
   // master byte: write data, wait for sixteen sck edges at the far end
   task automatic xfer(input logic [7:0] d);
      int e0;
      int n;
      e0 = far.edges;
      n = 0;
      wr(DATA_ADDR, d);
      while (far.edges < e0 + 16 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      repeat (6) @(posedge clk);
      if (n >= 5000) err_count++;
   endtask
   // ****************
   // scenarios
   // ****************
   task automatic t_regs;
      rchk(CTRL_ADDR, CTRL_RESET);
      rchk(STATUS_ADDR, 8'h08);
      rchk(12'h0FC, 8'h00);
      wr(CTRL_ADDR, 8'h5B);
      rchk(CTRL_ADDR, 8'h5B);
      check(pinsOut.sckOut, 1'b1);
      // a byte-sized transfer is refused and leaves control alone
      hsize <= 3'h0;
      wr(CTRL_ADDR, 8'h00);
      hsize <= AHB_WORD;
      rchk(CTRL_ADDR, 8'h5B);
      wr(CTRL_ADDR, 8'h53);
      repeat (2) @(posedge clk);
      check(pinsOut.sckOut, 1'b0);
   endtask
   // clearing enable mid-byte stops the engine
   task automatic t_abort;
      int e0;
      wr(DATA_ADDR, 8'h11);
      repeat (40) @(posedge clk);
      wr(CTRL_ADDR, 8'h13);
      e0 = far.edges;
      repeat (40) @(posedge clk);
      check(far.edges, e0);
      rchk(STATUS_ADDR, 8'h08);
   endtask
   // two bytes without reading: second one is an overrun and is dropped
   task automatic t_master;
      wr(CTRL_ADDR, 8'h53);
      wr(STATUS_ADDR, 8'h02);
      far.load(8'h3C);
      xfer(8'hA5);
      check(far.slvRx_r, 8'hA5);
      check(irq, 1'b1);
      wr(STATUS_ADDR, 8'h00);
      far.load(8'hC3);
      xfer(8'h5A);
      rchk(STATUS_ADDR, 8'hA8);
      rchk(DATA_ADDR, 8'h3C);
      rchk(STATUS_ADDR, 8'h08);
      check(irq, 1'b0);
   endtask
   task automatic t_rates;
      int          c;
      logic [31:0] rd;
      for (c = 1; c <= 6; c++) begin
         wr(CTRL_ADDR, 8'h50 | {c[2], 5'h00, c[1:0]});
         xfer(8'h0F);
         check(far.lastHalf, 2 << (c - 1));
         bus(1'b0, STATUS_ADDR, 8'h00, rd);
         bus(1'b0, DATA_ADDR, 8'h00, rd);
      end
   endtask
   // fault only clears by status read then control write, in that order
   task automatic t_mfault;
      wr(STATUS_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h53);
      far.selectLevel(1'b0);
      repeat (10) @(posedge clk);
      check(irq, 1'b1);
      rchk(CTRL_ADDR, 8'h03);
      wr(CTRL_ADDR, 8'h03);
      rchk(STATUS_ADDR, 8'h19);
      wr(CTRL_ADDR, 8'h03);
      far.selectLevel(1'b1);
      rchk(STATUS_ADDR, 8'h09);
      check(irq, 1'b0);
      wr(CTRL_ADDR, 8'h73);
      far.selectLevel(1'b0);
      repeat (10) @(posedge clk);
      rchk(STATUS_ADDR, 8'h09);
      check(pinsOut.sckOe, 1'b1);
      far.selectLevel(1'b1);
      wr(STATUS_ADDR, 8'h00);
   endtask
   // slave: whole byte, aborted byte giving a fault, then a fresh byte
   task automatic t_slave;
      wr(CTRL_ADDR, 8'h43);
      wr(DATA_ADDR, 8'h69);
      far.send(8'h96, 16);
      check(far.mRx_r, 8'h69);
      check(irq, 1'b1);
      rchk(STATUS_ADDR, 8'h88);
      rchk(DATA_ADDR, 8'h96);
      far.send(8'hFF, 2);
      repeat (8) @(posedge clk);
      rchk(STATUS_ADDR, 8'h18);
      wr(CTRL_ADDR, 8'h43);
      far.send(8'h5A, 16);
      rchk(STATUS_ADDR, 8'h88);
      rchk(DATA_ADDR, 8'h5A);
   endtask
   // invalid rate codes never start; pending data masks the empty interrupt
   task automatic t_badrate;
      int e0;
      e0 = far.edges;
      wr(CTRL_ADDR, 8'h50);
      wr(DATA_ADDR, 8'h33);
      wr(CTRL_ADDR, 8'hD3);
      wr(DATA_ADDR, 8'h44);
      repeat (200) @(posedge clk);
      check(far.edges, e0);
      wr(STATUS_ADDR, 8'h02);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
      wr(CTRL_ADDR, 8'h14);
   endtask
   task automatic t_txe;
      wr(STATUS_ADDR, 8'h02);
      repeat (2) @(posedge clk);
      check(irq, 1'b1);
      wr(STATUS_ADDR, 8'h00);
      repeat (2) @(posedge clk);
      check(irq, 1'b0);
   endtask
   task automatic report_and_stop;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      reset  = 1'b1;
      hsel   = 1'b0;
      haddr  = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = AHB_WORD;
      hwdata = 32'h0000_0000;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_abort;
      t_master;
      t_rates;
      t_mfault;
      t_slave;
      t_txe;
      t_badrate;
      report_and_stop;
   end
   // watchdog: twenty thousand cycles, several times the whole run
   initial begin
      #100_000;
      err_count++;
      report_and_stop;
   end
endmodule
bind sfc_spi_ctrl sfc_spi_ctrl_assertions chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .pinsIn(pinsIn), .pinsOut(pinsOut));
`default_nettype wire
